// File: bench/memsel_decoder_asserts.sv
// memsel_decoder_asserts: port-level checks of select priority, drive and standby.
// assumes it is bound onto memsel_decoder, one clk_in domain, nrst_in async low.
`timescale 1ns/10ps
`default_nettype none
module memsel_decoder_asserts (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n_out,
    input wire logic [7:0] primary_sector_selects_out,
    input wire logic [3:0] secondary_sector_selects_out,
    input wire logic sram_select_out,
    input wire logic config_select_out,
    input wire logic [7:0] page_bits_out,
    input wire logic [81:0] pld_input_bus_out,
    input wire logic pld_standby_out
);
    // all checks share the core clock and the reset
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    // sram must silence both flash arrays
    property p_sram_wins;
        sram_select_out |-> (primary_sector_selects_out | secondary_sector_selects_out) == 8'h00;
    endproperty
    a_sram_wins: assert property (p_sram_wins) else $error("sram lost overlap");
    // a secondary sector silences every primary sector
    property p_sec_wins;
        secondary_sector_selects_out != 4'h0 |-> primary_sector_selects_out == 8'h00;
    endproperty
    a_sec_wins: assert property (p_sec_wins) else $error("secondary lost overlap");
    // the config select excludes the sram select and every primary sector
    property p_level_one;
        config_select_out |-> !sram_select_out && primary_sector_selects_out == 8'h00;
    endproperty
    a_level_one: assert property (p_level_one) else $error("level order broken");
    // at most one primary and one secondary sector at a time
    property p_prim_one;
        $onehot0(primary_sector_selects_out);
    endproperty
    a_prim_one: assert property (p_prim_one) else $error("two primary selects");
    property p_sec_one;
        $onehot0(secondary_sector_selects_out);
    endproperty
    a_sec_one: assert property (p_sec_one) else $error("two secondary selects");
    // the bus is driven only for a decoded register read
    property p_drive_cfg;
        !data_oe_n_out |-> config_select_out;
    endproperty
    a_drive_cfg: assert property (p_drive_cfg) else $error("drive without select");
    property p_idle_zero;
        data_oe_n_out |-> data_out == 8'h00;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("data not zero when idle");
    // page bits reach the logic array bus one edge later while awake
    property p_page_bus;
        !pld_standby_out |=> pld_input_bus_out[64:57] == $past(page_bits_out);
    endproperty
    a_page_bus: assert property (p_page_bus) else $error("page bits not on bus");
    // the pld input bus holds still while standby lasts
    property p_standby_frozen;
        pld_standby_out && $past(pld_standby_out) |-> $stable(pld_input_bus_out);
    endproperty
    a_standby_frozen: assert property (p_standby_frozen) else $error("bus moved in standby");
    c_sram: cover property (sram_select_out);
    c_read: cover property (!data_oe_n_out);
    c_standby: cover property ($rose(pld_standby_out));
endmodule : memsel_decoder_asserts
bind memsel_decoder memsel_decoder_asserts i_memsel_decoder_asserts (.clk_in(clk_in),
    .nrst_in(nrst_in), .data_out(data_out), .data_oe_n_out(data_oe_n_out),
    .primary_sector_selects_out(primary_sector_selects_out),
    .secondary_sector_selects_out(secondary_sector_selects_out),
    .sram_select_out(sram_select_out), .config_select_out(config_select_out),
    .page_bits_out(page_bits_out), .pld_input_bus_out(pld_input_bus_out),
    .pld_standby_out(pld_standby_out));
`default_nettype wire

// File: bench/memsel_host.sv
// memsel_host: host bus model with write, read and program fetch cycles.
// assumes the decoder's 3-flop pin sync; strobes idle high, held 8 periods.
`timescale 1ns/10ps
`default_nettype none
module memsel_host (
    input wire logic clk_in,
    input wire logic [7:0] data_in, // read data from the decoder
    input wire logic data_oe_n_in, // low while the decoder drives
    input wire logic [12:0] sel_in, // sram, secondary, primary selects
    output logic [19:0] addr_out,
    output logic [7:0] data_out,
    output logic wr_n_out,
    output logic rd_n_out,
    output logic program_space_strobe_n_out
);
    // idle bus at time zero
    initial begin
        addr_out = 20'h00000;
        data_out = 8'h00;
        {wr_n_out, rd_n_out, program_space_strobe_n_out} = 3'b111;
    end
    // one cycle: kind 0 write, 1 read, 2 program fetch; snapshot taken before release
    task automatic cycle(input int kind, input logic [19:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic drv, output logic [12:0] sel);
        @(posedge clk_in);
        #1;
        addr_out = a;
        data_out = (kind == 0) ? d : ~data_out; // released data shows no stale value
        wr_n_out = (kind != 0);
        rd_n_out = (kind != 1);
        program_space_strobe_n_out = (kind != 2);
        repeat (8) @(posedge clk_in); // low well over the 4-period minimum
        q = data_in;
        drv = !data_oe_n_in;
        sel = sel_in;
        #1;
        {wr_n_out, rd_n_out, program_space_strobe_n_out} = 3'b111;
        repeat (8) @(posedge clk_in); // high time, address and data still held
        #1; // whatever the caller drives next lands off the edge
    endtask : cycle
endmodule : memsel_host
`default_nettype wire

// File: bench/tb.sv
// tb: self-checking bench for memsel_decoder driven through the host model.
// assumes the package default decode tables and a 25 ns clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("Error %0t: got %h expected %h", $time, (g), (e)); end end
module tb
    import memsel_pkg::*;
;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic split = 1'b0; // separate space mode
    logic prst = 1'b0; // pld reset level
    logic powerdown_input = 1'b0; // powerdown level
    logic rdy = 1'b0; // flash ready
    logic [7:0] pa = 8'h00, pb = 8'h00, pc = 8'h00, pf = 8'h00;
    logic [3:0] pd = 4'h0;
    logic [15:0] fb = 16'h0000;
    logic [19:0] addr;
    logic [7:0] wdata, rdata, page;
    logic oe_n, wr_n, rd_n, program_space_strobe_n, sram, cfg, stby, jtag;
    logic [1:0] peri;
    logic [7:0] prim;
    logic [3:0] sec;
    logic [81:0] pld;
    logic [7:0] q;
    logic drv;
    logic [12:0] sel;
    int err_count = 0;
    int checks = 0;
    // free-running 40 MHz clock
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    memsel_decoder i_memsel_decoder (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr),
        .data_in(wdata), .data_out(rdata), .data_oe_n_out(oe_n),
        .host_control_line_0_in(wr_n), .host_control_line_1_in(rd_n),
        .host_control_line_2_in(program_space_strobe_n), .split_space_in(split), .pld_reset_in(prst),
        .powerdown_input_in(powerdown_input), .port_a_in(pa), .port_b_in(pb), .port_c_in(pc),
        .port_d_in(pd), .port_f_in(pf), .macrocell_fb_in(fb), .flash_ready_in(rdy),
        .primary_sector_selects_out(prim), .secondary_sector_selects_out(sec),
        .sram_select_out(sram), .config_select_out(cfg), .jtag_select_out(jtag),
        .periph_selects_out(peri), .page_bits_out(page), .pld_input_bus_out(pld),
        .pld_standby_out(stby));
    memsel_host i_memsel_host (.clk_in(clk_in), .data_in(rdata), .data_oe_n_in(oe_n),
        .sel_in({sram, sec, prim}), .addr_out(addr), .data_out(wdata), .wr_n_out(wr_n),
        .rd_n_out(rd_n), .program_space_strobe_n_out(program_space_strobe_n));
    // verdict and end of run
    task automatic final_report;
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    // overlapping ranges resolve by level; an unmapped address gets no drive
    task automatic t_priority;
        logic [15:0] a [4] = '{16'h8100, 16'h9000, 16'ha000, 16'h4000};
        logic [12:0] e [4] = '{13'h1000, 13'h0100, 13'h0001, 13'h0000};
        for (int i = 0; i < 4; i++) begin
            i_memsel_host.cycle(1, {4'h0, a[i]}, 8'h00, q, drv, sel);
            `CHK(sel, e[i]);
            `CHK(drv, 1'b0);
            `CHK({jtag, peri}, 3'h0);
        end
    endtask : t_priority
    // page register write, bus copy and read back
    task automatic t_page;
        i_memsel_host.cycle(0, 20'h002e0, 8'ha5, q, drv, sel);
        `CHK(page, 8'ha5);
        `CHK(pld[64:57], 8'ha5);
        i_memsel_host.cycle(1, 20'h002e0, 8'h00, q, drv, sel);
        `CHK({drv, q}, 9'h1a5);
        `CHK(cfg, 1'b1);
    endtask : t_page
    // id registers ignore writes; an unmapped offset is not driven
    task automatic t_ids;
        i_memsel_host.cycle(0, 20'h002f0, 8'h00, q, drv, sel);
        i_memsel_host.cycle(1, 20'h002f0, 8'h00, q, drv, sel);
        `CHK({drv, q}, {1'b1, ID0_DEF});
        i_memsel_host.cycle(1, 20'h002f1, 8'h00, q, drv, sel);
        `CHK({drv, q}, {1'b1, ID1_DEF});
        i_memsel_host.cycle(1, 20'h002e5, 8'h00, q, drv, sel);
        `CHK(drv, 1'b0);
    endtask : t_ids
    // split spaces follow the mapping register, changed live
    task automatic t_mapping;
        i_memsel_host.cycle(1, 20'h002e2, 8'h00, q, drv, sel);
        `CHK(q, VM_INIT_DEF);
        split = 1'b1;
        i_memsel_host.cycle(2, 20'ha0000, 8'h00, q, drv, sel);
        `CHK(sel, 13'h0001);
        i_memsel_host.cycle(1, 20'ha0000, 8'h00, q, drv, sel);
        `CHK(sel, 13'h0000);
        i_memsel_host.cycle(1, 20'h90000, 8'h00, q, drv, sel);
        `CHK(sel, 13'h0100);
        `CHK(pld[15:0], 16'h9000);
        split = 1'b0;
        i_memsel_host.cycle(0, 20'h002e2, 8'h14, q, drv, sel);
        split = 1'b1;
        i_memsel_host.cycle(1, 20'ha0000, 8'h00, q, drv, sel);
        `CHK(sel, 13'h0001);
        split = 1'b0;
    endtask : t_mapping
    // pld input bus layout and control line blocking
    task automatic t_pld;
        {pa, pb, pc, pf, pd, fb} = {32'h11223344, 4'h5, 16'h6677};
        {prst, powerdown_input, rdy} = 3'b111;
        repeat (8) @(posedge clk_in);
        `CHK(pld[56:21], {4'h5, 32'h44332211});
        `CHK({pld[81], pld[80:65], pld[20:16]}, {1'b1, 16'h6677, 5'h1f});
        i_memsel_host.cycle(0, 20'h002b4, 8'h1f, q, drv, sel);
        `CHK(pld[20:16], 5'h00);
        i_memsel_host.cycle(0, 20'h002b4, 8'h00, q, drv, sel);
    endtask : t_pld
    // quiet inputs enter standby unless turbo is set
    task automatic t_standby;
        int n;
        n = 0;
        while (stby !== 1'b1 && n < 20) begin
            @(posedge clk_in);
            n++;
        end
        `CHK(stby, 1'b1);
        @(posedge clk_in);
        #1;
        pa = 8'h99;
        repeat (8) @(posedge clk_in);
        `CHK({stby, pld[28:21]}, 9'h099);
        i_memsel_host.cycle(0, 20'h002b0, 8'h08, q, drv, sel);
        repeat (20) @(posedge clk_in);
        `CHK(stby, 1'b0);
    endtask : t_standby
    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        final_report();
    end
    // reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        repeat (4) @(posedge clk_in);
        t_priority();
        t_page();
        t_ids();
        t_mapping();
        t_pld();
        t_standby();
        final_report();
    end
endmodule : tb
`default_nettype wire

// File: common/memsel_pkg.sv
// memsel_pkg: constants shared by the memory select decoder and its term matcher.
// assumes a 40 MHz core clock and an 8-bit register space behind a host bus.
`default_nettype none
package memsel_pkg;
    // clock and standby timing
    localparam int CLK_PERIOD_NS = 25; // core clock period
    localparam int STANDBY_NS = 70; // quiet time before standby
    localparam int STANDBY_CYC = (STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] STANDBY_LAST = 2'(STANDBY_CYC - 1);
    // decode key: page bits above a 16-bit address
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 8;
    localparam int KEY_W = ADDR_W + PAGE_W;
    localparam int TERMS = 3; // product terms per select
    // select numbering inside the decode array
    localparam int SEL_PRIM = 0; // eight primary sectors
    localparam int SEL_SEC = 8; // four secondary sectors
    localparam int SEL_SRAM = 12;
    localparam int SEL_CONFIG_REGISTER_SPACE = 13;
    localparam int SEL_JTAG = 14;
    localparam int SEL_PERI = 15; // two peripheral selects
    localparam int SEL_CNT = 17;
    localparam int TBL_W = SEL_CNT * TERMS * KEY_W;
    // synchronised pin vector layout
    localparam int P_ADDR = 0; // 20 address pins
    localparam int P_DATA = 20; // 8 data pins
    localparam int P_WR = 28; // control line 0, write, low
    localparam int P_RD = 29; // control line 1, read, low
    localparam int P_PROGRAM_SPACE_STROBE = 30; // control line 2, program, low
    localparam int P_SPLIT = 31; // separate space mode pin
    localparam int P_RST = 32;
    localparam int P_PDN = 33;
    localparam int P_PA = 34;
    localparam int P_PB = 42;
    localparam int P_PC = 50;
    localparam int P_PF = 58;
    localparam int P_PD = 66; // four port d inputs
    localparam int PIN_W = 70;
    localparam int SPLIT_SHIFT = 4; // A19-A4 in separate space mode
    localparam int PLD_W = 82;
    // register offsets inside the configuration space
    localparam logic [7:0] OFS_PM0 = 8'hb0;
    localparam logic [7:0] OFS_PM2 = 8'hb4;
    localparam logic [7:0] OFS_PAGE = 8'he0;
    localparam logic [7:0] OFS_VM = 8'he2;
    localparam logic [7:0] OFS_ID0 = 8'hf0;
    localparam logic [7:0] OFS_ID1 = 8'hf1;
    // space mapping register bits
    localparam int VM_SRAM_PS = 0;
    localparam int VM_SEC_PS = 1;
    localparam int VM_PRIM_PS = 2;
    localparam int VM_SEC_DS = 3;
    localparam int VM_PRIM_DS = 4;
    localparam logic [7:0] VM_INIT_DEF = 8'h0c;
    localparam int PM0_TURBO = 3;
    localparam int PM2_BLK_W = 5; // cntl0..2, reset, powerdown
    localparam logic [7:0] PM0_RST = 8'h00;
    localparam logic [7:0] PM2_RST = 8'h00;
    localparam logic [7:0] PAGE_RST = 8'h00;
    // arbitrary memory configuration codes
    localparam logic [7:0] ID0_DEF = 8'h5a;
    localparam logic [7:0] ID1_DEF = 8'h3c;
    // default decode: primary 0, secondary 0, sram and config space
    localparam logic [KEY_W-1:0] FS0_VAL = 24'h008000;
    localparam logic [KEY_W-1:0] FS0_MSK = 24'h00c000;
    localparam logic [KEY_W-1:0] SB0_VAL = 24'h008000;
    localparam logic [KEY_W-1:0] SB0_MSK = 24'h00e000;
    localparam logic [KEY_W-1:0] RS_VAL = 24'h008000;
    localparam logic [KEY_W-1:0] RS_MSK = 24'h00f800;
    localparam logic [KEY_W-1:0] IO_VAL = 24'h000200;
    localparam logic [KEY_W-1:0] IO_MSK = 24'h00ff00;

    // builds the default term table, term 0 of each listed select
    function automatic logic [TBL_W-1:0] memsel_def_tbl(input logic get_mask);
        logic [TBL_W-1:0] v;
        v = '0;
        v[SEL_PRIM*TERMS*KEY_W +: KEY_W] = get_mask ? FS0_MSK : FS0_VAL;
        v[SEL_SEC*TERMS*KEY_W +: KEY_W] = get_mask ? SB0_MSK : SB0_VAL;
        v[SEL_SRAM*TERMS*KEY_W +: KEY_W] = get_mask ? RS_MSK : RS_VAL;
        v[SEL_CONFIG_REGISTER_SPACE*TERMS*KEY_W +: KEY_W] = get_mask ? IO_MSK : IO_VAL;
        return v;
    endfunction : memsel_def_tbl

    localparam logic [TBL_W-1:0] DEF_TERM_VAL = memsel_def_tbl(1'b0);
    localparam logic [TBL_W-1:0] DEF_TERM_MSK = memsel_def_tbl(1'b1);
    localparam logic [SEL_CNT*TERMS-1:0] DEF_TERM_EN = 51'h0_0090_0100_0001;
endpackage : memsel_pkg
`default_nettype wire

// File: src/memsel_decoder.sv
// memsel_decoder: select decoder, page and mapping registers, pld input bus.
// assumes host pins are asynchronous to clk_in and a single 40 MHz clock.
`default_nettype none
`timescale 1ns/10ps
module memsel_decoder
    import memsel_pkg::*;
#(
    parameter logic [TBL_W-1:0] TERM_VAL = DEF_TERM_VAL,
    parameter logic [TBL_W-1:0] TERM_MSK = DEF_TERM_MSK,
    parameter logic [SEL_CNT*TERMS-1:0] TERM_EN = DEF_TERM_EN,
    parameter logic [7:0] VM_INIT = VM_INIT_DEF,
    parameter logic [7:0] ID0_VAL = ID0_DEF, // arbitrary value
    parameter logic [7:0] ID1_VAL = ID1_DEF // arbitrary value
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [19:0] addr_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n_out,
    input wire logic host_control_line_0_in,
    input wire logic host_control_line_1_in,
    input wire logic host_control_line_2_in,
    input wire logic split_space_in,
    input wire logic pld_reset_in,
    input wire logic powerdown_input_in,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_b_in,
    input wire logic [7:0] port_c_in,
    input wire logic [3:0] port_d_in,
    input wire logic [7:0] port_f_in,
    input wire logic [15:0] macrocell_fb_in,
    input wire logic flash_ready_in,
    output logic [7:0] primary_sector_selects_out,
    output logic [3:0] secondary_sector_selects_out,
    output logic sram_select_out,
    output logic config_select_out,
    output logic jtag_select_out,
    output logic [1:0] periph_selects_out,
    output logic [7:0] page_bits_out,
    output logic [PLD_W-1:0] pld_input_bus_out,
    output logic pld_standby_out
);

    // all state of the decoder
    typedef struct packed {
        logic [PIN_W-1:0] s1; // first synchroniser stage
        logic [PIN_W-1:0] s2; // second stage
        logic [PIN_W-1:0] s3; // third stage
        logic [PIN_W-1:0] pin; // accepted pin levels
        logic [7:0] page; // memory page register
        logic [7:0] vm; // space mapping register
        logic [7:0] pm0; // power management 0
        logic [7:0] pm2; // power management 2
        logic wr_prev; // last accepted write strobe
        logic [7:0] prim; // primary sector selects
        logic [3:0] sec; // secondary sector selects
        logic sram; // sram select
        logic config_register_space; // config space select
        logic jtag; // jtag select
        logic [1:0] peri; // peripheral selects
        logic [PLD_W-1:0] pld; // pld input bus
        logic [7:0] dout; // read data
        logic doe_n; // data drive enable, low drives
        logic [1:0] idle; // quiet cycles seen
        logic standby; // pld standby
    } memsel_state_t;

    memsel_state_t state_ff; // registered state
    memsel_state_t nxt_state; // next state
    logic [PIN_W-1:0] pins_raw; // asynchronous pins gathered
    logic [ADDR_W-1:0] dec_addr; // address used by decode
    logic [SEL_CNT-1:0] raw_sel; // unqualified select terms
    logic [PLD_W-1:0] pld_nxt; // freshly built pld bus
    logic [7:0] prim_q; // qualified primary selects
    logic [3:0] sec_q; // qualified secondary selects
    logic sram_q; // qualified sram select
    logic config_register_space_q; // qualified config select
    logic jtag_q; // qualified jtag select
    logic [1:0] peri_q; // qualified peripheral selects
    logic lvl1; // any level one target hit
    logic lvl2; // any secondary target hit
    logic wr_act; // write strobe asserted
    logic rd_act; // read strobe asserted
    logic ps_act; // program strobe asserted
    logic data_act; // data space access
    logic split; // separate space mode
    logic [7:0] ofs; // offset in config space
    logic reg_wr; // register write this cycle
    logic [7:0] rd_data; // read mux output
    logic rd_hit; // offset is a readable register
    logic [2:0] cntl_gated; // control lines past blocking
    logic rst_gated; // reset past blocking
    logic pdn_gated; // powerdown past blocking
    logic changed; // pld bus differs from last
    logic [PIN_W-1:0] agree; // stages two and three equal

    // gather every asynchronous pin into one vector
    assign pins_raw = {port_d_in, port_f_in, port_c_in, port_b_in, port_a_in,
                       powerdown_input_in, pld_reset_in, split_space_in,
                       host_control_line_2_in, host_control_line_1_in,
                       host_control_line_0_in, data_in, addr_in};

    // accepted pin state only moves when the late stages agree
    assign agree = ~(state_ff.s2 ^ state_ff.s3);

    // separate space mode takes the upper address window
    assign split = state_ff.pin[P_SPLIT];
    assign dec_addr = split ? state_ff.pin[P_ADDR + SPLIT_SHIFT +: ADDR_W]
                            : state_ff.pin[P_ADDR +: ADDR_W];

    // decode array: each select is up to three product terms
    for (genvar s = 0; s < SEL_CNT; s++) begin : g_sel
        memsel_term_match #(
            .N_TERMS(TERMS),
            .W(KEY_W),
            .VAL(TERM_VAL[s*TERMS*KEY_W +: TERMS*KEY_W]),
            .MSK(TERM_MSK[s*TERMS*KEY_W +: TERMS*KEY_W]),
            .EN(TERM_EN[s*TERMS +: TERMS])
        ) u_match (
            .key_in({state_ff.page, dec_addr}),
            .hit_out(raw_sel[s])
        );
    end

    // qualification by host strobes and the space mapping register
    always_comb begin
        wr_act = ~state_ff.pin[P_WR];
        rd_act = ~state_ff.pin[P_RD];
        ps_act = ~state_ff.pin[P_PROGRAM_SPACE_STROBE];
        data_act = rd_act | wr_act;
        if (split) begin
            // program fetch and data read each see their own memories
            prim_q = raw_sel[SEL_PRIM +: 8] & {8{(ps_act & state_ff.vm[VM_PRIM_PS]) |
                     (data_act & state_ff.vm[VM_PRIM_DS])}};
            sec_q = raw_sel[SEL_SEC +: 4] & {4{(ps_act & state_ff.vm[VM_SEC_PS]) |
                    (data_act & state_ff.vm[VM_SEC_DS])}};
            sram_q = raw_sel[SEL_SRAM] &
                     (data_act | (ps_act & state_ff.vm[VM_SRAM_PS]));
            config_register_space_q = raw_sel[SEL_CONFIG_REGISTER_SPACE] & data_act;
            peri_q = raw_sel[SEL_PERI +: 2] & {2{data_act}};
        end else begin
            // combined space: decode stands on address alone
            prim_q = raw_sel[SEL_PRIM +: 8];
            sec_q = raw_sel[SEL_SEC +: 4];
            sram_q = raw_sel[SEL_SRAM];
            config_register_space_q = raw_sel[SEL_CONFIG_REGISTER_SPACE];
            peri_q = raw_sel[SEL_PERI +: 2];
        end
        jtag_q = raw_sel[SEL_JTAG];
        // level one: sram, config io, peripheral io
        lvl1 = sram_q | config_register_space_q | (|peri_q);
        // level two: secondary flash
        lvl2 = |sec_q;
        // lower levels drop out under a higher hit
        sec_q = lvl1 ? '0 : sec_q;
        prim_q = (lvl1 | lvl2) ? '0 : prim_q;
    end

    // register access inside the configuration space
    always_comb begin
        ofs = state_ff.pin[P_ADDR +: 8];
        // a write lands on the rising edge of the write strobe
        reg_wr = ~state_ff.wr_prev & state_ff.pin[P_WR] & raw_sel[SEL_CONFIG_REGISTER_SPACE];
        rd_hit = 1'b1;
        unique case (ofs)
            OFS_PAGE: rd_data = state_ff.page;
            OFS_VM: rd_data = state_ff.vm;
            OFS_PM0: rd_data = state_ff.pm0;
            OFS_PM2: rd_data = state_ff.pm2;
            OFS_ID0: rd_data = ID0_VAL;
            OFS_ID1: rd_data = ID1_VAL;
            default: begin
                // unmapped offset: nothing answers
                rd_data = '0;
                rd_hit = 1'b0;
            end
        endcase
    end

    // pld input bus with blocking of control lines
    always_comb begin
        cntl_gated = state_ff.pin[P_WR +: 3] & ~state_ff.pm2[2:0];
        rst_gated = state_ff.pin[P_RST] & ~state_ff.pm2[3];
        pdn_gated = state_ff.pin[P_PDN] & ~state_ff.pm2[PM2_BLK_W-1];
        pld_nxt = {flash_ready_in, macrocell_fb_in, state_ff.page,
                   state_ff.pin[P_PD +: 4], state_ff.pin[P_PF +: 8],
                   state_ff.pin[P_PC +: 8], state_ff.pin[P_PB +: 8],
                   state_ff.pin[P_PA +: 8], pdn_gated, rst_gated,
                   cntl_gated, dec_addr};
        changed = (pld_nxt != state_ff.pld);
    end

    // next state
    always_comb begin
        nxt_state = state_ff;
        // three-stage pin synchroniser
        nxt_state.s1 = pins_raw;
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
        nxt_state.pin = (state_ff.s3 & agree) | (state_ff.pin & ~agree);
        nxt_state.wr_prev = state_ff.pin[P_WR];
        // host writes to the configuration registers
        if (reg_wr) begin
            unique case (ofs)
                OFS_PAGE: nxt_state.page = state_ff.pin[P_DATA +: 8];
                OFS_VM: nxt_state.vm = state_ff.pin[P_DATA +: 8];
                OFS_PM0: nxt_state.pm0 = state_ff.pin[P_DATA +: 8];
                OFS_PM2: nxt_state.pm2 = state_ff.pin[P_DATA +: 8];
                default: begin
                    // ids and unmapped offsets ignore writes
                end
            endcase
        end
        // data drive only for a mapped register read; a frozen config select
        // that is low must not be contradicted by the drive
        if (rd_act & config_register_space_q & rd_hit & (~state_ff.standby | state_ff.config_register_space)) begin
            nxt_state.dout = rd_data;
            nxt_state.doe_n = 1'b0;
        end else begin
            nxt_state.dout = '0;
            nxt_state.doe_n = 1'b1;
        end
        // standby handling of the pld outputs
        if (state_ff.standby) begin
            // asleep: outputs hold, a change wakes the array
            if (changed) begin
                nxt_state.standby = 1'b0;
                nxt_state.idle = '0;
            end
        end else begin
            // awake: outputs follow the decode
            nxt_state.pld = pld_nxt;
            nxt_state.prim = prim_q;
            nxt_state.sec = sec_q;
            nxt_state.sram = sram_q;
            nxt_state.config_register_space = config_register_space_q;
            nxt_state.jtag = jtag_q;
            nxt_state.peri = peri_q;
            if (changed | state_ff.pm0[PM0_TURBO]) begin
                nxt_state.idle = '0;
            end else if (state_ff.idle == STANDBY_LAST) begin
                nxt_state.standby = 1'b1;
            end else begin
                nxt_state.idle = state_ff.idle + 2'h1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= '0;
            state_ff.s1 <= '1;
            state_ff.s2 <= '1;
            state_ff.s3 <= '1;
            state_ff.pin <= '1;
            state_ff.wr_prev <= 1'b1;
            state_ff.page <= PAGE_RST;
            state_ff.vm <= VM_INIT;
            state_ff.pm0 <= PM0_RST;
            state_ff.pm2 <= PM2_RST;
            state_ff.doe_n <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // outputs straight from the state register
    assign primary_sector_selects_out = state_ff.prim;
    assign secondary_sector_selects_out = state_ff.sec;
    assign sram_select_out = state_ff.sram;
    assign config_select_out = state_ff.config_register_space;
    assign jtag_select_out = state_ff.jtag;
    assign periph_selects_out = state_ff.peri;
    assign page_bits_out = state_ff.page;
    assign pld_input_bus_out = state_ff.pld;
    assign pld_standby_out = state_ff.standby;
    assign data_out = state_ff.dout;
    assign data_oe_n_out = state_ff.doe_n;
endmodule : memsel_decoder
`default_nettype wire

// File: src/memsel_term_match.sv
// memsel_term_match: one decode select built as an or of product terms.
// assumes key and table come from the same clock domain; purely combinational.
`default_nettype none
`timescale 1ns/10ps
module memsel_term_match
    import memsel_pkg::*;
#(
    parameter int N_TERMS = TERMS,
    parameter int W = KEY_W,
    parameter logic [N_TERMS*W-1:0] VAL = '0,
    parameter logic [N_TERMS*W-1:0] MSK = '0,
    parameter logic [N_TERMS-1:0] EN = '0
) (
    input wire logic [W-1:0] key_in,
    output logic hit_out
);
    logic [N_TERMS-1:0] term_hit; // per product term match

    // each enabled term compares the masked key with its value
    for (genvar t = 0; t < N_TERMS; t++) begin : g_term
        assign term_hit[t] = EN[t] &
            ((key_in & MSK[t*W +: W]) == (VAL[t*W +: W] & MSK[t*W +: W]));
    end

    // the select is the sum of its terms
    assign hit_out = |term_hit;
endmodule : memsel_term_match
`default_nettype wire
